/* File: logic/autoneg_cfg.svh */
// Register map, field positions and reset values of the negotiation block
`ifndef AUTONEG_CFG_SVH
`define AUTONEG_CFG_SVH
`define REG_CTRL 5'h00
`define REG_STAT 5'h01
`define REG_ADV 5'h04
`define REG_LPA 5'h05
`define REG_EXP 5'h06
`define REG_NPT 5'h07
`define CTL_RST 15
`define CTL_EN 12
`define CTL_RESTART 9
`define STAT_DONE 5
`define STAT_ABLE 3
`define EXP_PDF 4
`define EXP_LPNP 3
`define EXP_NP 2
`define EXP_PR 1
`define EXP_LPAN 0
`define W_NP 15
`define W_ACK 14
`define W_TOGGLE 11
`define ACK_MASK 16'hbfff
`define NPT_DEFAULT 16'h2001
`define NPT_WMASK 16'hb7ff
`define NPT_TOGGLE 16'h0800
`define ADV_DEFAULT 16'h01e1
`define NP_ABLE 1'b1
`define ACK_WORDS 4'h6
`define AB_10 5
`define AB_10FD 6
`define AB_TX 7
`define AB_TXFD 8
`define AB_T4 9
`define ZERO16 16'h0000
`endif

/* File: logic/autoneg_pkg.sv */
// Types shared by the negotiation management and PMA control block
package autoneg_pkg;
	typedef enum logic [1:0] {LS_FAIL = 2'h0, LS_READY = 2'h1, LS_OK = 2'h2} link_status_t;
	typedef enum logic [1:0] {LC_SCAN = 2'h0, LC_DISABLE = 2'h1, LC_ENABLE = 2'h2} link_control_t;
	typedef enum logic [1:0] {TECH_NONE = 2'h0, TECH_10 = 2'h1, TECH_TX = 2'h2, TECH_T4 = 2'h3} tech_t;
	typedef enum logic [2:0] {
		ST_DISABLE = 3'h0,
		ST_ABILITY = 3'h1,
		ST_ACK = 3'h3,
		ST_COMPLETE = 3'h2,
		ST_LINK_OK = 3'h6,
		ST_NP_WAIT = 3'h7,
		ST_PD = 3'h5
	} an_state_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} mgmt_req_t;
	typedef struct packed {
		link_status_t pulse_integrity_test;
		link_status_t tx;
		link_status_t t4;
	} pma_status_t;
	typedef struct packed {
		link_control_t pulse_integrity_test;
		link_control_t full_integrity_test;
		link_control_t tx;
		link_control_t t4;
	} pma_control_t;
endpackage

/* File: logic/autoneg_mgmt.sv */
// Negotiation management registers, word matching and PMA link control
//
// Notes on behaviour
// - Local advertised ability vector lives in all sixteen bits of register 4.
// - Partner ability vector received is shown in all bits of register 5.
// - Next page words sent are taken from register 7 except bit 15 (gated) and bit 14 (acknowledge).
// - Any write to register 7 sets the extra page loaded flag.
// - Only the arbitration machine clears the extra page loaded flag.
// - Partner able to negotiate shows at register 6 bit 0.
// - Partner supports next pages shows at register 6 bit 3.
// - Register 0 bits 12, 15, 9 give enable, main reset, restart.
// - Done at 1.5, page arrived at 6.1, detect fault at 6.4.
// - Register 1 bit 3 reads one since negotiation is present.
// - Without management a fixed default supplies the advertised abilities.
// - Next page bit sent with the local flag; on next pages it also needs the partner flag and the loaded flag clear.
// - Base word kept apart from next page data so restart always works.
// - PMA status is ready, ok or fail; data undefined unless ok.
// - Scan mode PMA only hunts carrier and reports ready.
// - Disable control value stops a PMA.
// - Enable control value hands normal work to exactly one PMA.
// - After reset with negotiation on, every PMA gets disable.
// - Transmit, receive and arbitration machines are implemented here.
// - Defaulted machine variables revert each state; register variables hold.
// - Ability match when three consecutive words agree apart from acknowledge.
// - Matching uses a sliding window of any three successive words.
// - Acknowledge match needs three identical words all with acknowledge set.
// - Acknowledge finished once the counted acknowledge words are sent.
// - A 10 Mb/s outcome enables the full integrity test, not pulse test.
// - Reading register 6 clears page arrived.
// - Reading register 6 clears detect fault.
// - Register 7 powers up holding the null message page.
`timescale 1ns/1ps
`include "autoneg_cfg.svh"
module autoneg_mgmt
	import autoneg_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input mgmt_req_t mgmt,
	output logic [15:0] mgmt_rdata,
	input pma_status_t pma_status,
	input wire logic rx_word_valid,
	input wire logic [15:0] rx_word,
	input wire logic tx_word_sent,
	output logic [15:0] tx_word,
	output pma_control_t pma_ctl,
	output tech_t chosen_technology,
	output logic negotiation_done
);
	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic same_noack(input logic [15:0] a, input logic [15:0] b);
		same_noack = ((a ^ b) & `ACK_MASK) == `ZERO16;
	endfunction

	function automatic logic is_ready(input link_status_t s);
		is_ready = (s == LS_READY);
	endfunction

	function automatic logic [1:0] ready_count(input pma_status_t s);
		ready_count = {1'b0, is_ready(s.pulse_integrity_test)} + {1'b0, is_ready(s.tx)} + {1'b0, is_ready(s.t4)};
	endfunction

	function automatic tech_t resolve(input logic [15:0] c);
		if (c[`AB_TXFD] || c[`AB_TX]) begin
			resolve = (c[`AB_TXFD] || !c[`AB_T4]) ? TECH_TX : TECH_T4;
		end else if (c[`AB_T4]) begin
			resolve = TECH_T4;
		end else if (c[`AB_10FD] || c[`AB_10]) begin
			resolve = TECH_10;
		end else begin
			resolve = TECH_NONE;
		end
	endfunction

	function automatic logic is_wr(input mgmt_req_t m, input logic [4:0] a);
		is_wr = m.wr && (m.addr == a);
	endfunction

	an_state_t state;
	an_state_t next_state;
	logic negotiation_on;
	logic management_reset;
	logic restart_request;
	logic [15:0] local_adv_vector;
	logic [15:0] partner_adv_vector;
	logic [15:0] extra_page_tx_vector;
	logic extra_page_loaded;
	logic partner_can_negotiate;
	logic partner_extra_pages_ok;
	logic page_arrived;
	logic detect_fault_flag;
	logic ability_match;
	logic acknowledge_match;
	logic ack_finished;
	logic [3:0] ack_left;
	logic [15:0] hist0;
	logic [15:0] hist1;
	logic [1:0] hist_cnt;
	logic np_mode;
	pma_status_t st_meta;
	pma_status_t st_sync;
	logic kill;
	logic halt;
	logic page_take;
	logic pd_fault;
	logic np_consume;
	logic more_pages;
	logic exp_read;
	tech_t pd_choice;

	assign kill = !rst_n || management_reset;
	assign halt = kill || restart_request || !negotiation_on;
	assign exp_read = mgmt.rd && (mgmt.addr == `REG_EXP);
	assign page_take = (state == ST_ABILITY) && ability_match;
	assign pd_fault = (state == ST_PD) && (ready_count(st_sync) != 2'h1);
	assign np_consume = (state == ST_NP_WAIT) && extra_page_loaded;
	assign more_pages = np_mode ? (extra_page_tx_vector[`W_NP] || partner_adv_vector[`W_NP])
		: (local_adv_vector[`W_NP] && `NP_ABLE && partner_extra_pages_ok);
	assign pd_choice = is_ready(st_sync.tx) ? TECH_TX : is_ready(st_sync.t4) ? TECH_T4 : TECH_10;

	// ****************************************
	// PMA status synchroniser
	// ****************************************
	// three valued status
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_meta <= {LS_FAIL, LS_FAIL, LS_FAIL};
			st_sync <= {LS_FAIL, LS_FAIL, LS_FAIL};
		end else begin
			st_meta <= pma_status;
			st_sync <= st_meta;
		end
	end

	// ****************************************
	// Control register
	// ****************************************
	// Reset and restart bits clear themselves after one cycle
	// control bit mapping
	always_ff @(posedge clk) begin
		if (kill) begin
			negotiation_on <= 1'b1;
			management_reset <= 1'b0;
			restart_request <= 1'b0;
		end else if (is_wr(mgmt, `REG_CTRL)) begin
			negotiation_on <= mgmt.wdata[`CTL_EN];
			management_reset <= mgmt.wdata[`CTL_RST];
			restart_request <= mgmt.wdata[`CTL_RESTART];
		end else begin
			restart_request <= 1'b0;
		end
	end

	// ****************************************
	// Advertisement and next page registers
	// ****************************************
	// fixed default source
	always_ff @(posedge clk) begin
		if (kill) begin
			local_adv_vector <= `ADV_DEFAULT;
		end else if (is_wr(mgmt, `REG_ADV)) begin
			local_adv_vector <= mgmt.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (kill) begin
			extra_page_tx_vector <= `NPT_DEFAULT;
		end else if (is_wr(mgmt, `REG_NPT)) begin
			extra_page_tx_vector <= (mgmt.wdata & `NPT_WMASK) | (extra_page_tx_vector & ~`NPT_WMASK);
		end else if (np_consume) begin
			extra_page_tx_vector[`W_TOGGLE] <= !extra_page_tx_vector[`W_TOGGLE];
		end
	end

	// Write wins over the consume in the same cycle
	// write sets loaded
	always_ff @(posedge clk) begin
		if (kill) begin
			extra_page_loaded <= 1'b0;
		end else if (is_wr(mgmt, `REG_NPT)) begin
			extra_page_loaded <= 1'b1;
		end else if (np_consume) begin
			extra_page_loaded <= 1'b0;
		end
	end

	// ****************************************
	// Partner and expansion status
	// ****************************************
	// partner vector
	always_ff @(posedge clk) begin
		if (kill) begin
			partner_adv_vector <= `ZERO16;
			partner_can_negotiate <= 1'b0;
			partner_extra_pages_ok <= 1'b0;
		end else if (page_take) begin
			partner_adv_vector <= hist0;
			if (!np_mode) begin
				partner_can_negotiate <= 1'b1;
				partner_extra_pages_ok <= hist0[`W_NP];
			end
		end
	end

	// Hardware set beats the read clear
	// read clears page
	always_ff @(posedge clk) begin
		if (kill) begin
			page_arrived <= 1'b0;
			detect_fault_flag <= 1'b0;
		end else begin
			if (page_take) begin
				page_arrived <= 1'b1;
			end else if (exp_read) begin
				page_arrived <= 1'b0;
			end
			if (pd_fault) begin
				detect_fault_flag <= 1'b1;
			end else if (exp_read) begin
				detect_fault_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// Received word matching
	// ****************************************
	// two word history
	always_ff @(posedge clk) begin
		if (halt || np_consume) begin
			hist0 <= `ZERO16;
			hist1 <= `ZERO16;
			hist_cnt <= 2'h0;
			ability_match <= 1'b0;
			acknowledge_match <= 1'b0;
		end else if (rx_word_valid) begin
			hist0 <= rx_word;
			hist1 <= hist0;
			hist_cnt <= (hist_cnt == 2'h2) ? 2'h2 : hist_cnt + 2'h1;
			ability_match <= (hist_cnt == 2'h2) && same_noack(rx_word, hist0)
				&& same_noack(hist0, hist1);
			acknowledge_match <= (hist_cnt == 2'h2) && (rx_word == hist0)
				&& (hist0 == hist1) && rx_word[`W_ACK];
		end else begin
			ability_match <= 1'b0;
			acknowledge_match <= 1'b0;
		end
	end

	// ****************************************
	// Acknowledge word counter
	// ****************************************
	// Finished drops as the machine leaves, so it never outlives the state
	// acknowledge finished
	always_ff @(posedge clk) begin
		if (halt || state != ST_COMPLETE || next_state != ST_COMPLETE) begin
			ack_left <= `ACK_WORDS;
			ack_finished <= 1'b0;
		end else if (tx_word_sent && ack_left != 4'h0) begin
			ack_left <= ack_left - 4'h1;
			ack_finished <= (ack_left == 4'h1);
		end
	end

	// ****************************************
	// Arbitration state machine
	// ****************************************
	// arbitration machine
	always_comb begin
		next_state = state;
		case (state)
			ST_DISABLE: begin
				next_state = ST_ABILITY;
			end
			ST_ABILITY: begin
				if (ability_match) begin
					next_state = ST_ACK;
				end else if (!np_mode && hist_cnt == 2'h0 && ready_count(st_sync) != 2'h0) begin
					next_state = ST_PD;
				end
			end
			ST_PD: begin
				next_state = pd_fault ? ST_DISABLE : ST_LINK_OK;
			end
			ST_ACK: begin
				if (acknowledge_match) begin
					next_state = ST_COMPLETE;
				end
			end
			ST_COMPLETE: begin
				if (ack_finished) begin
					if (more_pages) begin
						next_state = ST_NP_WAIT;
					end else if (resolve(local_adv_vector & partner_adv_vector) == TECH_NONE) begin
						next_state = ST_DISABLE;
					end else begin
						next_state = ST_LINK_OK;
					end
				end
			end
			ST_NP_WAIT: begin
				if (extra_page_loaded) begin
					next_state = ST_ABILITY;
				end
			end
			ST_LINK_OK: begin
				if (st_sync.pulse_integrity_test == LS_FAIL && st_sync.tx == LS_FAIL && st_sync.t4 == LS_FAIL) begin
					next_state = ST_DISABLE;
				end
			end
			default: begin
				next_state = ST_DISABLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (halt) begin
			state <= ST_DISABLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (halt || state == ST_DISABLE) begin
			np_mode <= 1'b0;
		end else if (np_consume) begin
			np_mode <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (halt) begin
			negotiation_done <= 1'b0;
			chosen_technology <= TECH_NONE;
		end else if (state == ST_PD && !pd_fault) begin
			negotiation_done <= 1'b1;
			chosen_technology <= pd_choice;
		end else if (state == ST_COMPLETE && next_state == ST_LINK_OK) begin
			negotiation_done <= 1'b1;
			chosen_technology <= resolve(local_adv_vector & partner_adv_vector);
		end else if (next_state == ST_DISABLE) begin
			negotiation_done <= 1'b0;
		end
	end

	// ****************************************
	// Transmit word
	// ****************************************
	// next page bit gating
	always_ff @(posedge clk) begin
		if (halt) begin
			tx_word <= `ZERO16;
		end else if (np_mode) begin
			tx_word <= extra_page_tx_vector;
			tx_word[`W_NP] <= extra_page_tx_vector[`W_NP] && `NP_ABLE
				&& partner_extra_pages_ok && extra_page_loaded == 1'b0;
			tx_word[`W_ACK] <= (state == ST_ACK) || (state == ST_COMPLETE);
		end else begin
			tx_word <= local_adv_vector;
			tx_word[`W_NP] <= local_adv_vector[`W_NP] && `NP_ABLE;
			tx_word[`W_ACK] <= (state == ST_ACK) || (state == ST_COMPLETE);
		end
	end

	// ****************************************
	// PMA link control
	// ****************************************
	// Full test stays off until a 10 Mb/s outcome
	// disable after reset
	always_ff @(posedge clk) begin
		if (halt || state == ST_DISABLE) begin
			pma_ctl <= {LC_DISABLE, LC_DISABLE, LC_DISABLE, LC_DISABLE};
		end else if (state == ST_LINK_OK) begin
			pma_ctl.pulse_integrity_test <= LC_DISABLE;
			pma_ctl.full_integrity_test <= (chosen_technology == TECH_10) ? LC_ENABLE : LC_DISABLE;
			pma_ctl.tx <= (chosen_technology == TECH_TX) ? LC_ENABLE : LC_DISABLE;
			pma_ctl.t4 <= (chosen_technology == TECH_T4) ? LC_ENABLE : LC_DISABLE;
		end else begin
			pma_ctl <= {LC_SCAN, LC_DISABLE, LC_SCAN, LC_SCAN};
		end
	end

	// ****************************************
	// Register read back
	// ****************************************
	// ability bit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mgmt_rdata <= `ZERO16;
		end else if (mgmt.rd) begin
			mgmt_rdata <= `ZERO16;
			case (mgmt.addr)
				`REG_CTRL: mgmt_rdata[`CTL_EN] <= negotiation_on;
				`REG_STAT: begin
					mgmt_rdata[`STAT_ABLE] <= 1'b1;
					mgmt_rdata[`STAT_DONE] <= negotiation_done;
				end
				`REG_ADV: mgmt_rdata <= local_adv_vector;
				`REG_LPA: mgmt_rdata <= partner_adv_vector;
				`REG_EXP: begin
					mgmt_rdata[`EXP_PDF] <= detect_fault_flag;
					mgmt_rdata[`EXP_LPNP] <= partner_extra_pages_ok;
					mgmt_rdata[`EXP_NP] <= `NP_ABLE;
					mgmt_rdata[`EXP_PR] <= page_arrived;
					mgmt_rdata[`EXP_LPAN] <= partner_can_negotiate;
				end
				`REG_NPT: mgmt_rdata <= extra_page_tx_vector & `NPT_WMASK
					| (extra_page_tx_vector & `NPT_TOGGLE);
				default: mgmt_rdata <= `ZERO16;
			endcase
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_np_write;
		mgmt.wr && mgmt.addr == `REG_NPT && !management_reset;
	endsequence
	sequence s_exp_read_quiet;
		exp_read && !page_take && !kill;
	endsequence

	property p_np_loaded;
		s_np_write |=> extra_page_loaded;
	endproperty
	a_np_loaded: assert property (p_np_loaded) else $error("loaded flag not set");

	property p_read_clear;
		s_exp_read_quiet |=> !page_arrived;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("page flag not cleared");

	property p_ack_implies_ability;
		acknowledge_match |-> ability_match;
	endproperty
	a_ack_implies_ability: assert property (p_ack_implies_ability) else $error("ack match alone");

	property p_one_enable;
		$countones({pma_ctl.full_integrity_test == LC_ENABLE, pma_ctl.tx == LC_ENABLE,
			pma_ctl.t4 == LC_ENABLE, pma_ctl.pulse_integrity_test == LC_ENABLE}) <= 1;
	endproperty
	a_one_enable: assert property (p_one_enable) else $error("two PMAs enabled");

	property p_lit_for_10;
		state == ST_LINK_OK && chosen_technology == TECH_10 && !halt
			|=> pma_ctl.full_integrity_test == LC_ENABLE && pma_ctl.pulse_integrity_test == LC_DISABLE;
	endproperty
	a_lit_for_10: assert property (p_lit_for_10) else $error("full test not enabled");

	property p_disable_after_halt;
		halt |=> pma_ctl.tx == LC_DISABLE && pma_ctl.t4 == LC_DISABLE ##1 pma_ctl.pulse_integrity_test != LC_ENABLE;
	endproperty
	a_disable_after_halt: assert property (p_disable_after_halt) else $error("PMA not disabled");

	property p_done_clear;
		restart_request |=> !negotiation_done;
	endproperty
	a_done_clear: assert property (p_done_clear) else $error("done survives restart");

	property p_stat_able;
		mgmt.rd && mgmt.addr == `REG_STAT |=> mgmt_rdata[`STAT_ABLE];
	endproperty
	a_stat_able: assert property (p_stat_able) else $error("ability bit low");

	property p_ack_finished;
		ack_finished |-> state == ST_COMPLETE && ack_left == 4'h0;
	endproperty
	a_ack_finished: assert property (p_ack_finished) else $error("early ack finish");

	property p_match_window;
		rx_word_valid && hist_cnt == 2'h2 && !halt && !np_consume && rx_word == hist0
			&& hist0 == hist1 |=> ability_match;
	endproperty
	a_match_window: assert property (p_match_window) else $error("three words missed");
endmodule

/* File: verification/pma_model.sv */
// Behavioural PMA set and word transmitter facing the negotiation block
`timescale 1ns/1ps
module pma_model(
	input wire logic clk,
	input wire logic rst_n,
	input autoneg_pkg::pma_control_t pma_ctl,
	input wire logic [2:0] carrier,
	input wire logic sending,
	output autoneg_pkg::pma_status_t pma_status,
	output logic tx_word_sent
);
	import autoneg_pkg::*;
	logic [1:0] gap;

	function automatic link_status_t answer(input link_control_t c, input logic cr);
		case (c)
			LC_SCAN: return cr ? LS_READY : LS_FAIL;
			LC_ENABLE: return cr ? LS_OK : LS_FAIL;
			default: return LS_FAIL;
		endcase
	endfunction

	// Carrier order is {nlp,tx,t4}
	always @(posedge clk) begin
		if (!rst_n)
			pma_status <= '{LS_FAIL, LS_FAIL, LS_FAIL};
		else
			pma_status <= '{answer(pma_ctl.pulse_integrity_test, carrier[2]), answer(pma_ctl.tx, carrier[1]),
				answer(pma_ctl.t4, carrier[0])};
	end

	// One word finished every four cycles while the bench lets it send
	always @(posedge clk) begin
		gap <= (!rst_n || !sending) ? 2'h0 : gap + 2'h1;
		tx_word_sent <= rst_n && sending && (gap == 2'h3);
	end
endmodule

/* File: verification/autoneg_mgmt_pma_interface_test.sv */
// Self-checking bench for the negotiation management block
`timescale 1ns/1ps
`include "autoneg_cfg.svh"
module autoneg_mgmt_pma_interface_test;
	import autoneg_pkg::*;
	localparam pma_control_t all_off = '{LC_DISABLE, LC_DISABLE, LC_DISABLE, LC_DISABLE};
	localparam pma_control_t hunting = '{LC_SCAN, LC_DISABLE, LC_SCAN, LC_SCAN};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	mgmt_req_t mgmt = '0;
	logic [15:0] mgmt_rdata;
	pma_status_t pma_status;
	logic rx_word_valid = 1'b0;
	logic [15:0] rx_word = 16'h0000;
	logic tx_word_sent;
	logic [15:0] tx_word;
	pma_control_t pma_ctl;
	tech_t chosen_technology;
	logic negotiation_done;
	logic [2:0] carrier = 3'h0;
	logic sending = 1'b0;
	int fails = 0;
	int num_checks = 0;

	always #5 clk = ~clk;

	autoneg_mgmt DUT (.clk(clk), .rst_n(rst_n), .mgmt(mgmt), .mgmt_rdata(mgmt_rdata),
		.pma_status(pma_status), .rx_word_valid(rx_word_valid), .rx_word(rx_word),
		.tx_word_sent(tx_word_sent), .tx_word(tx_word), .pma_ctl(pma_ctl),
		.chosen_technology(chosen_technology), .negotiation_done(negotiation_done));

	pma_model far_side (.clk(clk), .rst_n(rst_n), .pma_ctl(pma_ctl), .carrier(carrier),
		.sending(sending), .pma_status(pma_status), .tx_word_sent(tx_word_sent));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic close_out;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic give_up(input string what);
		fails++;
		$display("[FAIL] %s expected event seen timeout", what);
		close_out();
	endtask

	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		mgmt <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		mgmt <= '0;
	endtask

	task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		mgmt <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk);
		mgmt <= '0;
		#1;
		d = mgmt_rdata;
	endtask

	task automatic reg_chk(input string what, input logic [4:0] a, input logic [15:0] m,
		input logic [15:0] exp);
		logic [15:0] d;
		reg_rd(a, d);
		check(what, exp, d & m);
	endtask

	task automatic send(input logic [15:0] w);
		@(posedge clk);
		rx_word_valid <= 1'b1;
		rx_word <= w;
		@(posedge clk);
		rx_word_valid <= 1'b0;
	endtask

	task automatic wait_ctl(input pma_control_t v, input int lim, input string what);
		int n;
		for (n = 0; n < lim && pma_ctl !== v; n++)
			@(posedge clk);
		if (n == lim)
			give_up(what);
	endtask

	task automatic wait_done(input logic v, input int lim, input string what);
		int n;
		for (n = 0; n < lim && negotiation_done !== v; n++)
			@(posedge clk);
		if (n == lim)
			give_up(what);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic reset_values;
		reg_chk("advert default", `REG_ADV, 16'hffff, 16'h01e1);
		reg_chk("next page default", `REG_NPT, 16'hffff, 16'h2001);
		reg_chk("status able", `REG_STAT, 16'h0028, 16'h0008);
		reg_chk("control", `REG_CTRL, 16'hffff, 16'h1000);
	endtask

	task automatic registers;
		reg_wr(`REG_ADV, 16'hbeef);
		reg_chk("advert rw", `REG_ADV, 16'hffff, 16'hbeef);
		reg_wr(`REG_LPA, 16'hffff);
		reg_chk("partner ro", `REG_LPA, 16'hffff, 16'h0000);
		reg_wr(`REG_EXP, 16'hffff);
		reg_chk("expansion ro", `REG_EXP, 16'hffff, 16'h0004);
		reg_wr(`REG_NPT, 16'hffff);
		reg_chk("next page rw", `REG_NPT, 16'hffff, 16'hb7ff);
		reg_wr(5'h03, 16'hffff);
		reg_chk("unmapped", 5'h03, 16'hffff, 16'h0000);
		reg_wr(`REG_CTRL, 16'h8000);
		reg_chk("advert after reset", `REG_ADV, 16'hffff, 16'h01e1);
		reg_chk("next page after reset", `REG_NPT, 16'hffff, 16'h2001);
		reg_wr(`REG_CTRL, 16'h0000);
		wait_ctl(all_off, 10, "disabled control");
		reg_chk("control off", `REG_CTRL, 16'hffff, 16'h0000);
		reg_wr(`REG_CTRL, 16'h1000);
		wait_ctl(hunting, 20, "scan control");
	endtask

	// Stray word first, so the match must come from a sliding window
	task automatic negotiate(input logic [15:0] w, input tech_t tech, input pma_control_t ctl);
		int n;
		int k;
		k = 0;
		send(16'h0001);
		repeat (3) send(w);
		for (n = 0; n < 50 && tx_word[`W_ACK] !== 1'b1; n++)
			@(posedge clk);
		if (n == 50)
			give_up("ack bit");
		check("base word", 16'h01e1, tx_word & 16'hbfff);
		reg_chk("partner word", `REG_LPA, 16'hffff, w);
		reg_chk("expansion set", `REG_EXP, 16'h000f, 16'h0007);
		reg_chk("expansion cleared", `REG_EXP, 16'h000f, 16'h0005);
		repeat (3) send(w | 16'h4000);
		repeat (40) @(posedge clk);
		check("held until ack words", 16'h0000, 16'(pma_ctl === ctl));
		// Only a TX outcome gets carrier, so only a TX link holds once enabled
		carrier <= (tech == TECH_TX) ? 3'b010 : 3'h0;
		sending <= 1'b1;
		for (n = 0; n < 200 && pma_ctl !== ctl; n++) begin
			@(posedge clk);
			k += int'(tx_word_sent);
		end
		if (n == 200)
			give_up("chosen control");
		check("ack words", 16'h0001, 16'(k >= 6 && k <= 7));
		check("technology", 16'(tech), 16'(chosen_technology));
	endtask

	task automatic link_up;
		@(posedge clk);
		carrier <= 3'b010;
		wait_done(1'b1, 300, "done rise");
		reg_chk("done bit", `REG_STAT, 16'h0028, 16'h0028);
	endtask

	task automatic restart;
		@(posedge clk);
		carrier <= 3'h0;
		sending <= 1'b0;
		reg_wr(`REG_CTRL, 16'h1200);
		wait_done(1'b0, 4, "done clear");
		wait_ctl(hunting, 40, "scan again");
	endtask

	// Both ends offer next pages, so the base exchange parks for a new page
	task automatic extra_pages;
		int n;
		reg_wr(`REG_ADV, 16'h8081);
		repeat (3) send(16'h8081);
		repeat (3) send(16'hc081);
		check("next page offered", 16'hc081, tx_word);
		reg_chk("partner next page", `REG_EXP, 16'h0008, 16'h0008);
		sending <= 1'b1;
		for (n = 0; n < 100 && tx_word[`W_ACK] !== 1'b0; n++)
			@(posedge clk);
		if (n == 100)
			give_up("next page wait");
		check("parked word", 16'h8081, tx_word);
		sending <= 1'b0;
		reg_wr(`REG_NPT, 16'h2005);
		repeat (3) @(posedge clk);
		check("next page sent", 16'h2805, tx_word);
		reg_chk("toggle read back", `REG_NPT, 16'hffff, 16'h2805);
	endtask

	task automatic parallel;
		logic [15:0] d;
		int n;
		@(posedge clk);
		carrier <= 3'b011;
		d = 16'h0000;
		for (n = 0; n < 200 && d[`EXP_PDF] !== 1'b1; n++)
			reg_rd(`REG_EXP, d);
		if (n == 200)
			give_up("detect fault");
		@(posedge clk);
		carrier <= 3'h0;
		repeat (20) @(posedge clk);
		// Detection ran again before carrier fell, so one more fault is latched
		reg_chk("fault latched", `REG_EXP, 16'h0010, 16'h0010);
		reg_chk("fault cleared", `REG_EXP, 16'h0010, 16'h0000);
		@(posedge clk);
		carrier <= 3'b001;
		wait_ctl('{LC_DISABLE, LC_DISABLE, LC_DISABLE, LC_ENABLE}, 5000, "t4 chosen");
		check("parallel tech", 16'(TECH_T4), 16'(chosen_technology));
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge clk);
		check("control in reset", 16'(all_off), 16'(pma_ctl));
		check("done in reset", 16'h0000, 16'(negotiation_done));
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		check("control after reset", 16'(all_off), 16'(pma_ctl));
		repeat (4) @(posedge clk);
		#1;
		check("scan after reset", 16'(hunting), 16'(pma_ctl));
		reset_values();
		registers();
		negotiate(16'h0081, TECH_TX, '{LC_DISABLE, LC_DISABLE, LC_ENABLE, LC_DISABLE});
		link_up();
		restart();
		negotiate(16'h0021, TECH_10, '{LC_DISABLE, LC_ENABLE, LC_DISABLE, LC_DISABLE});
		restart();
		extra_pages();
		restart();
		parallel();
		close_out();
	end
endmodule
